// [bench/pic_core_model.sv]
// Behavioural model of the core that takes vectored requests.
// Assumes core_req is a one-cycle pulse synchronous to clk.
`timescale 1ns/100ps
module pic_core_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       resetn,
  // Request from the controller.
  input  wire logic       core_req,
  input  wire logic [4:0] core_vector,
  // Log of what was taken.
  output int              taken_cnt,
  output logic [4:0]      taken_vec
);
  // Each pulse is one taken request; the vector is latched with it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      taken_cnt <= 0;
      taken_vec <= 5'h00;
    end else if (core_req) begin
      taken_cnt <= taken_cnt + 1;
      taken_vec <= core_vector;
    end
  end
endmodule

// [bench/test_pic_controller.sv]
// Self-checking bench for the prioritised interrupt controller.
// Assumes pic_pkg, the controller and the core model are compiled first.
`timescale 1ns/100ps
module test_pic_controller
  import pic_pkg::*;
;
  logic        clk;
  logic        resetn;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [27:0] src_req;
  logic        core_req;
  logic [4:0]  core_vector;
  logic        irq;
  int          taken_cnt;
  logic [4:0]  taken_vec;
  int          err_count;
  int          total_checks;

  pic_controller u_pic_controller (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src_req(src_req), .core_req(core_req),
    .core_vector(core_vector), .irq(irq)
  );

  pic_core_model u_pic_core_model (
    .clk(clk), .resetn(resetn), .core_req(core_req),
    .core_vector(core_vector), .taken_cnt(taken_cnt),
    .taken_vec(taken_vec)
  );

  // --------------------------------------------------------------------
  // Bus and compare helpers
  // --------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [15:0] a,
                        input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  task automatic pulse(input logic [27:0] m);
    @(posedge clk);
    src_req <= m;
    @(posedge clk);
    src_req <= 28'h0000000;
  endtask

  task automatic wait_req(input int lim, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(posedge clk);
      #1;
      seen = (core_req === 1'b1);
    end
  endtask

  task automatic expect_req(input logic [4:0] v);
    logic seen;
    wait_req(12, seen);
    chk("core_req", 16'h0001, {15'h0000, seen});
    chk("core_vector", {11'h000, v}, {11'h000, core_vector});
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rd_chk("reset value", PIC_ADDR_EN_LOW0 + 16'(i), 16'h0000);
    end
    rd_chk("unmapped", 16'hFC1F, 16'h0000);
  endtask

  task automatic t_poll();
    logic seen;
    pulse(28'h80000FF);
    wait_req(6, seen);
    chk("no request", 16'h0000, {15'h0000, seen});
    rd_chk("pend0", PIC_ADDR_PEND0, 16'h00FF);
    rd_chk("pend1", PIC_ADDR_PEND1, 16'h0800);
    wr(PIC_ADDR_PEND0, 16'hF00F);
    rd_chk("pend0 w1c", PIC_ADDR_PEND0, 16'h00F0);
    wr(PIC_ADDR_PEND0, 16'hFFFF);
    wr(PIC_ADDR_PEND1, 16'hFFFF);
    rd_chk("pend1 w1c", PIC_ADDR_PEND1, 16'h0000);
  endtask

  task automatic t_forward();
    logic seen;
    wr(PIC_ADDR_EN_LOW0, 16'h0020);
    pulse(28'h0000020);
    expect_req(5'h05);
    rd_chk("pend0 auto", PIC_ADDR_PEND0, 16'h0000);
    rd_chk("count", PIC_ADDR_NEST, 16'h0001);
    rd_chk("vector", PIC_ADDR_VECTOR, 16'h0005);
    chk("model vector", 16'h0005, {11'h000, taken_vec});
    pulse(28'h0000020);
    wait_req(6, seen);
    chk("held", 16'h0000, {15'h0000, seen});
    rd_chk("pend0 held", PIC_ADDR_PEND0, 16'h0020);
    wr(PIC_ADDR_GENA, 16'h0000);
    expect_req(5'h05);
    // Handler end: one enable write undoes the issue increment.
    wr(PIC_ADDR_GENA, 16'h1234);
    rd_chk("count back", PIC_ADDR_NEST, 16'h0000);
  endtask

  task automatic t_same();
    @(posedge clk);
    src_req  <= 28'h0000020;
    @(posedge clk);
    src_req  <= 28'h0000000;
    reg_addr <= PIC_ADDR_GDIS;
    reg_wr   <= 1'b1;
    @(posedge clk);
    reg_wr   <= 1'b0;
    #1;
    chk("issue", 16'h0001, {15'h0000, core_req});
    rd_chk("count two", PIC_ADDR_NEST, 16'h0002);
    wr(PIC_ADDR_GENA, 16'h0000);
    wr(PIC_ADDR_GENA, 16'h0000);
    wr(PIC_ADDR_EN_LOW0, 16'h0000);
  endtask

  task automatic t_count();
    // count moved only through disable and enable writes.
    wr(PIC_ADDR_GDIS, 16'hFFFF);
    rd_chk("count one", PIC_ADDR_NEST, 16'h0001);
    for (int i = 0; i < 7; i++) begin
      wr(PIC_ADDR_GDIS, 16'h0000);
    end
    rd_chk("count sat", PIC_ADDR_NEST, 16'h0007);
    for (int i = 0; i < 8; i++) begin
      wr(PIC_ADDR_GENA, 16'h0000);
    end
    rd_chk("count floor", PIC_ADDR_NEST, 16'h0000);
  endtask

  task automatic t_prio();
    logic [4:0] order [5] = '{5'h19, 5'h09, 5'h14, 5'h0C, 5'h03};
    wr(PIC_ADDR_EN_LOW0, 16'h0208);
    wr(PIC_ADDR_EN_HIGH0, 16'h1200);
    wr(PIC_ADDR_EN_LOW1, 16'hF200);
    wr(PIC_ADDR_EN_HIGH1, 16'h0210);
    rd_chk("en_low1", PIC_ADDR_EN_LOW1, 16'h0200);
    rd_chk("en_high0", PIC_ADDR_EN_HIGH0, 16'h1200);
    wr(PIC_ADDR_GDIS, 16'h0000);
    pulse(28'h2101208);
    for (int i = 0; i < 5; i++) begin
      wr(PIC_ADDR_GENA, 16'h0000);
      expect_req(order[i]);
    end
    wr(PIC_ADDR_GENA, 16'h0000);
    chk("model count", 16'h0008, 16'(taken_cnt));
  endtask

  task automatic t_irq();
    rd_chk("event status", PIC_ADDR_EVT_STAT, 16'h0003);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(PIC_ADDR_EVT_EN, 16'h0001);
    #1;
    chk("irq raised", 16'h0001, {15'h0000, irq});
    wr(PIC_ADDR_EVT_CLR, 16'h0001);
    #1;
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    wr(PIC_ADDR_EVT_EN, 16'h0002);
    #1;
    chk("irq sat", 16'h0001, {15'h0000, irq});
    wr(PIC_ADDR_EVT_EN, 16'h0000);
    #1;
    chk("irq off", 16'h0000, {15'h0000, irq});
    wr(PIC_ADDR_EVT_CLR, 16'h0003);
    rd_chk("status clear", PIC_ADDR_EVT_STAT, 16'h0000);
  endtask

  // Reset in mid-run with enables, held flags and a vector in place.
  task automatic t_midreset();
    wr(PIC_ADDR_GDIS, 16'h0000);
    pulse(28'h0000208);
    rd_chk("pend0 before reset", PIC_ADDR_PEND0, 16'h0208);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd_chk("en_low0 after reset", PIC_ADDR_EN_LOW0, 16'h0000);
    rd_chk("en_high0 after reset", PIC_ADDR_EN_HIGH0, 16'h0000);
    rd_chk("pend0 after reset", PIC_ADDR_PEND0, 16'h0000);
    rd_chk("vector after reset", PIC_ADDR_VECTOR, 16'h0000);
    rd_chk("count after reset", PIC_ADDR_NEST, 16'h0000);
    chk("vector pin after reset", 16'h0000, {11'h000, core_vector});
  endtask

  // --------------------------------------------------------------------
  // Clock, sequence, watchdog and verdict
  // --------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Free-running 4 ns clock.
  always #2 clk = ~clk;

  // Reset for 16 cycles, then run every scenario in turn.
  initial begin
    clk          = 1'b0;
    resetn       = 1'b0;
    reg_addr     = 16'h0000;
    reg_wdata    = 16'h0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    src_req      = 28'h0000000;
    err_count    = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_poll();
    t_forward();
    t_same();
    t_count();
    t_prio();
    t_irq();
    t_midreset();
    test_done();
  end

  // The tests need well under a thousand cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule

// [src/pic_controller.sv]
// Prioritised interrupt controller top: register port, origin flags,
// enables, nesting counter and vectored request to the core.
// Assumes src_req pulses and register strobes are synchronous to clk.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module pic_controller
  import pic_pkg::*;
#(
  parameter int unsigned NUM_SRC = PIC_NUM_SRC
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port.
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // Peripheral request pulses.
  input  wire logic [27:0] src_req,
  // Vectored request to the core.
  output logic             core_req,
  output logic [4:0]       core_vector,
  // Controller event interrupt.
  output logic             irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [27:0] en_low_q;
  logic [27:0] en_high_q;
  logic [27:0] pend_q;
  logic [27:0] pend_d;
  logic [4:0]  vector_q;
  logic [2:0]  nest_q;
  logic [2:0]  nest_d;
  logic        core_req_q;
  logic [1:0]  evt_stat_q;
  logic [1:0]  evt_en_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  logic wr_en_low0;
  logic wr_en_low1;
  logic wr_en_high0;
  logic wr_en_high1;
  logic wr_pend0;
  logic wr_pend1;
  logic wr_nest;
  logic wr_gdis;
  logic wr_gena;
  logic wr_evt_clr;
  logic wr_evt_en;

  // Write strobes for each register except the read-only vector and event status.
  assign wr_en_low0  = reg_wr && (reg_addr == PIC_ADDR_EN_LOW0);
  assign wr_en_low1  = reg_wr && (reg_addr == PIC_ADDR_EN_LOW1);
  assign wr_en_high0 = reg_wr && (reg_addr == PIC_ADDR_EN_HIGH0);
  assign wr_en_high1 = reg_wr && (reg_addr == PIC_ADDR_EN_HIGH1);
  assign wr_pend0    = reg_wr && (reg_addr == PIC_ADDR_PEND0);
  assign wr_pend1    = reg_wr && (reg_addr == PIC_ADDR_PEND1);
  assign wr_nest     = reg_wr && (reg_addr == PIC_ADDR_NEST);
  assign wr_gdis     = reg_wr && (reg_addr == PIC_ADDR_GDIS);
  assign wr_gena     = reg_wr && (reg_addr == PIC_ADDR_GENA);
  assign wr_evt_clr  = reg_wr && (reg_addr == PIC_ADDR_EVT_CLR);
  assign wr_evt_en   = reg_wr && (reg_addr == PIC_ADDR_EVT_EN);

  // ----------------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------------
  // split by source range.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_low_q <= PIC_RST_ENABLE;
    end else begin
      if (wr_en_low0) begin
        en_low_q[15:0] <= reg_wdata;
      end
      if (wr_en_low1) begin
        en_low_q[27:16] <= reg_wdata[11:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_high_q <= PIC_RST_ENABLE;
    end else begin
      if (wr_en_high0) begin
        en_high_q[15:0] <= reg_wdata;
      end
      if (wr_en_high1) begin
        en_high_q[27:16] <= reg_wdata[11:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Selection and forwarding
  // ----------------------------------------------------------------------
  logic        sel_valid;
  logic [4:0]  sel_index;
  pic_level_e  sel_level;
  logic        issue;
  logic [27:0] issue_clr;
  logic [27:0] sw_clr;

  pic_prio_sel u_sel (
    .clk       (clk),
    .resetn    (resetn),
    .pending   (pend_q),
    .en_low    (en_low_q),
    .en_high   (en_high_q),
    .sel_valid (sel_valid),
    .sel_index (sel_index),
    .sel_level (sel_level)
  );

  assign issue = sel_valid && (nest_q == PIC_RST_NEST);

  // One-hot clear of the flag being forwarded.
  assign issue_clr = issue ? (28'h0000001 << sel_index) : 28'h0000000;

  // Clears requested by software on either origin register.
  assign sw_clr = {(wr_pend1 ? reg_wdata[11:0] : 12'h000),
                   (wr_pend0 ? reg_wdata : 16'h0000)};

  // ----------------------------------------------------------------------
  // Origin flags
  // ----------------------------------------------------------------------
  // pulse sets, and wins over any clear.
  assign pend_d = (pend_q & ~sw_clr & ~issue_clr) | src_req;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_q <= PIC_RST_PEND;
    end else begin
      pend_q <= pend_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_req_q <= 1'b0;
      vector_q   <= PIC_RST_VECTOR;
    end else begin
      core_req_q <= issue;
      if (issue) begin
        vector_q <= sel_index;
      end
    end
  end

  assign core_req    = core_req_q;
  assign core_vector = vector_q;

  // ----------------------------------------------------------------------
  // Nesting counter
  // ----------------------------------------------------------------------
  logic       nest_dec;
  logic [1:0] nest_inc;
  logic [2:0] nest_base;
  logic [3:0] nest_raw;
  logic       nest_sat;

  assign nest_dec  = wr_gena && (nest_q != PIC_RST_NEST);
  assign nest_base = nest_dec ? (nest_q - 3'h1) : nest_q;
  assign nest_inc  = {1'b0, issue} + {1'b0, wr_gdis};
  assign nest_raw  = {1'b0, nest_base} + {2'b00, nest_inc};
  assign nest_sat  = !wr_nest && nest_raw[3];

  // a direct write simply loads the value.
  always_comb begin
    if (wr_nest) begin
      nest_d = reg_wdata[2:0];
    end else begin
      nest_d = pic_sat_add(nest_base, nest_inc);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nest_q <= PIC_RST_NEST;
    end else begin
      nest_q <= nest_d;
    end
  end

  // ----------------------------------------------------------------------
  // Controller events
  // ----------------------------------------------------------------------
  logic [1:0] evt_set;
  logic [1:0] evt_clr;

  // Sticky bits: request sent, and count held at its ceiling.
  assign evt_set = {nest_sat, issue};
  assign evt_clr = wr_evt_clr ? reg_wdata[1:0] : 2'h0;

  // Set wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_stat_q <= PIC_RST_EVT;
    end else begin
      evt_stat_q <= (evt_stat_q & ~evt_clr) | evt_set;
    end
  end

  // Event enable mask.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_en_q <= PIC_RST_EVT;
    end else if (wr_evt_en) begin
      evt_en_q <= reg_wdata[1:0];
    end
  end

  assign irq = |(evt_stat_q & evt_en_q);

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // count is readable.
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        PIC_ADDR_EN_LOW0:  rdata_d = en_low_q[15:0];
        PIC_ADDR_EN_LOW1:  rdata_d = {4'h0, en_low_q[27:16]};
        PIC_ADDR_EN_HIGH0: rdata_d = en_high_q[15:0];
        PIC_ADDR_EN_HIGH1: rdata_d = {4'h0, en_high_q[27:16]};
        PIC_ADDR_PEND0:    rdata_d = pend_q[15:0];
        PIC_ADDR_PEND1:    rdata_d = {4'h0, pend_q[27:16]};
        PIC_ADDR_VECTOR:   rdata_d = {11'h000, vector_q};
        PIC_ADDR_NEST:     rdata_d = {13'h0000, nest_q};
        PIC_ADDR_EVT_STAT: rdata_d = {14'h0000, evt_stat_q};
        PIC_ADDR_EVT_EN:   rdata_d = {14'h0000, evt_en_q};
        default:           rdata_d = 16'h0000;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Flags of disabled sources that software is not clearing this cycle.
  logic [27:0] hold_mask;
  assign hold_mask = pend_q & ~(en_low_q | en_high_q) & ~sw_clr;

  AST_SEND_VECTOR: assert property (
    @(posedge clk) disable iff (!resetn)
    issue |=> (core_req && core_vector == $past(sel_index)))
    else $error("core request or vector wrong after send");
  AST_SEND_CLEARS_FLAG: assert property (
    @(posedge clk) disable iff (!resetn)
    (issue && !src_req[sel_index]) |=> !pend_q[$past(sel_index)])
    else $error("forwarded flag not cleared");
  AST_SET_ALWAYS: assert property (
    @(posedge clk) disable iff (!resetn)
    (|src_req) |=> ((pend_q & $past(src_req)) == $past(src_req)))
    else $error("request pulse did not set its flag");
  AST_W1C: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr_pend0 && !issue && src_req == 28'h0000000) |=>
      (pend_q[15:0] == ($past(pend_q[15:0]) & ~$past(reg_wdata))))
    else $error("origin write did not clear exactly the written ones");
  AST_DISABLED_STAYS: assert property (
    @(posedge clk) disable iff (!resetn)
    (|hold_mask) |=> ((pend_q & $past(hold_mask)) == $past(hold_mask)))
    else $error("disabled source flag lost without a clear");
  AST_NO_SEND_NONZERO: assert property (
    @(posedge clk) disable iff (!resetn)
    (nest_q != 3'h0) |=> !core_req)
    else $error("request forwarded while count non-zero");
  AST_SEND_INC: assert property (
    @(posedge clk) disable iff (!resetn)
    (issue && !wr_gdis && !wr_nest && !wr_gena) |=> (nest_q == 3'h1))
    else $error("send did not raise count by one");
  AST_DIS_INC: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr_gdis && !issue && nest_q < 3'h7) |=>
      (nest_q == $past(nest_q) + 3'h1))
    else $error("disable write did not raise count");
  AST_DIS_SEND_TWO: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr_gdis && issue) |=> (nest_q == 3'h2))
    else $error("send with disable write did not add two");
  AST_ENA_DEC: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr_gena && nest_q != 3'h0) |=> (nest_q == $past(nest_q) - 3'h1))
    else $error("enable write did not lower count");
  AST_SATURATE: assert property (
    @(posedge clk) disable iff (!resetn)
    (nest_q == 3'h7 && wr_gdis) |=> (nest_q == 3'h7))
    else $error("count wrapped past seven");
  AST_READ_COUNT: assert property (
    @(posedge clk) disable iff (!resetn)
    (reg_rd && reg_addr == PIC_ADDR_NEST) |=>
      (reg_rdata == {13'h0000, $past(nest_q)}))
    else $error("count read returned wrong value");
  AST_VECTOR_RANGE: assert property (
    @(posedge clk) disable iff (!resetn)
    core_req |-> (vector_q <= 5'h1B))
    else $error("vector out of range");

  COV_SEND: cover property (
    @(posedge clk) disable iff (!resetn) issue ##1 core_req);
  COV_DIS_AND_SEND: cover property (
    @(posedge clk) disable iff (!resetn) issue && wr_gdis);
  COV_COMPETE: cover property (
    @(posedge clk) disable iff (!resetn)
    issue && sel_level == PIC_LVL_HIGH &&
    ($countones(pend_q & (en_low_q | en_high_q)) > 1));
  COV_REENABLE: cover property (
    @(posedge clk) disable iff (!resetn)
    (wr_gena && nest_q == 3'h1) ##1 issue);

endmodule

// [src/pic_pkg.sv]
// Constants, types and helper functions for the prioritised interrupt
// controller.
// Assumes a single clock domain and a 16-bit register port.
package pic_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned PIC_NUM_SRC = 28;
  localparam int unsigned PIC_ADDR_W  = 16;
  localparam int unsigned PIC_DATA_W  = 16;
  localparam int unsigned PIC_LO_W    = 16;
  localparam int unsigned PIC_HI_W    = 12;
  localparam int unsigned PIC_VEC_W   = 5;
  localparam int unsigned PIC_CNT_W   = 3;
  localparam int unsigned PIC_EVT_W   = 2;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] PIC_ADDR_EN_LOW0  = 16'hFC00;
  localparam logic [15:0] PIC_ADDR_EN_LOW1  = 16'hFC01;
  localparam logic [15:0] PIC_ADDR_EN_HIGH0 = 16'hFC02;
  localparam logic [15:0] PIC_ADDR_EN_HIGH1 = 16'hFC03;
  localparam logic [15:0] PIC_ADDR_PEND0    = 16'hFC04;
  localparam logic [15:0] PIC_ADDR_PEND1    = 16'hFC05;
  localparam logic [15:0] PIC_ADDR_VECTOR   = 16'hFC06;
  localparam logic [15:0] PIC_ADDR_NEST     = 16'hFC07;
  localparam logic [15:0] PIC_ADDR_GDIS     = 16'hFC08;
  localparam logic [15:0] PIC_ADDR_GENA     = 16'hFC09;
  localparam logic [15:0] PIC_ADDR_EVT_STAT = 16'hFC0A;
  localparam logic [15:0] PIC_ADDR_EVT_CLR  = 16'hFC0B;
  localparam logic [15:0] PIC_ADDR_EVT_EN   = 16'hFC0C;

  // ----------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [27:0] PIC_RST_ENABLE = 28'h0000000;
  localparam logic [27:0] PIC_RST_PEND   = 28'h0000000;
  localparam logic [4:0]  PIC_RST_VECTOR = 5'h00;
  localparam logic [2:0]  PIC_RST_NEST   = 3'h0;
  localparam logic [1:0]  PIC_RST_EVT    = 2'h0;
  localparam logic [2:0]  PIC_NEST_MAX   = 3'h7;
  localparam int unsigned PIC_EVT_ISSUED = 0;
  localparam int unsigned PIC_EVT_SAT    = 1;

  // Priority level of one source, coded as {high bit, low bit}.
  typedef enum logic [1:0] {
    PIC_LVL_OFF  = 2'b00,
    PIC_LVL_LOW  = 2'b01,
    PIC_LVL_MED  = 2'b10,
    PIC_LVL_HIGH = 2'b11
  } pic_level_e;

  // Saturating add of a small amount to the nesting count.
  function automatic logic [2:0] pic_sat_add(input logic [2:0] cnt,
                                             input logic [1:0] amt);
    logic [3:0] sum;
    sum = {1'b0, cnt} + {2'b00, amt};
    return sum[3] ? PIC_NEST_MAX : sum[2:0];
  endfunction

  // Index of the highest set bit, zero when none is set.
  function automatic logic [4:0] pic_msb_index(input logic [27:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 0; i < 28; i++) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

endpackage

// [src/pic_prio_sel.sv]
// Priority selector: picks the pending enabled source of highest level,
// highest source number first within a level.
// Assumes pending and enable vectors come from flops of the same clock.
`timescale 1ns/100ps
module pic_prio_sel
  import pic_pkg::*;
(
  // Clock and reset, used by the checks only.
  input  wire logic        clk,
  input  wire logic        resetn,
  // Source state.
  input  wire logic [27:0] pending,
  input  wire logic [27:0] en_low,
  input  wire logic [27:0] en_high,
  // Selection.
  output logic             sel_valid,
  output logic [4:0]       sel_index,
  output pic_level_e       sel_level
);

  logic [27:0] lvl_high;
  logic [27:0] lvl_med;
  logic [27:0] lvl_low;
  logic [27:0] win_mask;

  // Split the pending enabled sources by level.
  assign lvl_high = pending & en_high & en_low;
  assign lvl_med  = pending & en_high & ~en_low;
  assign lvl_low  = pending & ~en_high & en_low;

  always_comb begin
    win_mask  = 28'h0000000;
    sel_level = PIC_LVL_OFF;
    if (|lvl_high) begin
      win_mask  = lvl_high;
      sel_level = PIC_LVL_HIGH;
    end else if (|lvl_med) begin
      win_mask  = lvl_med;
      sel_level = PIC_LVL_MED;
    end else if (|lvl_low) begin
      win_mask  = lvl_low;
      sel_level = PIC_LVL_LOW;
    end
  end

  assign sel_index = pic_msb_index(win_mask);
  assign sel_valid = |win_mask;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_PRIO_HIGH_FIRST: assert property (
    @(posedge clk) disable iff (!resetn)
    (|lvl_high) |-> (sel_valid && en_high[sel_index] && en_low[sel_index]))
    else $error("high level source not chosen first");

  AST_TIE_HIGHEST_NUM: assert property (
    @(posedge clk) disable iff (!resetn)
    sel_valid |-> (((win_mask >> sel_index) >> 1) == 28'h0000000))
    else $error("tie not broken to highest source number");

endmodule
